// >>> hbridge_chop_pkg.sv
// constants, types and tables shared by the h-bridge chop controller
// How it works
// - enabled: direction picks which output goes high
// - bridge drives only while enable input high
// - disabled, slow decay: both low sides stay on
// - disabled, fast decay: reverse until zero, then coast
// - decay low is slow, high is fast
// - undriven decay pin selects mixed decay
// - drive until threshold, then decay until period end
// - threshold compares amplified sense with scaled reference
// - codes 00-0f map to 0..67 percent
// - codes 10-1f map to 71..100 percent
// - slow decay turns on both low sides
// - fast decay reverses bridge, releases near zero current
// - sense ignored for 3.75 us after drive starts
// - logic reset halts bridge, ignores all inputs except overcurrent and sleep
// - sleep stops bridge, pump, regulator, clocks
// - about 1 ms wake delay after sleep
// - undriven control inputs read as low
// - chopping period is 50 kHz
// - sustained overcurrent latches fault until logic reset
package hbridge_chop_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PWM_FREQ_KHZ  = 50;
    localparam int PWM_PERIOD_NS = 1000000 / PWM_FREQ_KHZ;
    localparam logic [10:0] PWM_CYC = 11'(PWM_PERIOD_NS / CLK_PERIOD_NS);
    localparam int BLANK_NS      = 3750;
    localparam logic [11:0] BLANK_CYC =
        12'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // fast part of a mixed decay interval
    localparam int MIX_FAST_NS   = 2500;
    localparam logic [11:0] MIX_FAST_CYC =
        12'((MIX_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int WAKE_US       = 1000;
    localparam int WAKE_CYC      =
        (WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIN_W         = 12;
    localparam logic [11:0] PIN_RESET = 12'h000;

    // percent of full scale per code, 0,5,10 .. 99,100,100
    localparam logic [6:0] SCALE_PCT [32] = '{
        7'h00, 7'h05, 7'h0a, 7'h0f, 7'h14, 7'h18, 7'h1d, 7'h22,
        7'h26, 7'h2b, 7'h2f, 7'h33, 7'h38, 7'h3c, 7'h3f, 7'h43,
        7'h47, 7'h4a, 7'h4d, 7'h50, 7'h53, 7'h56, 7'h58, 7'h5a,
        7'h5c, 7'h5e, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h64};

    // pins after synchronisation
    typedef struct packed {
        logic       ocp;
        logic       lp_n;
        logic       lrst_n;
        logic       decay_open;
        logic       decay_lvl;
        logic       en;
        logic       dir;
        logic [4:0] code;
    } pin_t;

    // gate drive of the four bridge switches
    typedef struct packed {
        logic a_hi;
        logic a_lo;
        logic b_hi;
        logic b_lo;
    } gate_t;

    typedef enum logic [4:0] {
        ST_HALT  = 5'b00001,
        ST_DRIVE = 5'b00010,
        ST_REV   = 5'b00100,
        ST_SLOW  = 5'b01000,
        ST_COAST = 5'b10000
    } state_t;

    typedef enum logic [2:0] {
        DK_SLOW  = 3'b001,
        DK_FAST  = 3'b010,
        DK_MIXED = 3'b100
    } decay_t;
endpackage

// >>> hbridge_current_chop_control.sv
// h-bridge direction, enable, decay and current-chop control logic
`timescale 1ns/1ps
module hbridge_current_chop_control #(
    parameter int WAKE_CYC = hbridge_chop_pkg::WAKE_CYC
) (
    // clock and chip reset
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    // host control pins, asynchronous
    input  wire logic                    direction_select,
    input  wire logic                    bridge_enable_in,
    input  wire logic                    recirculation_select,
    input  wire logic                    recirculation_open,
    input  wire logic [4:0]              current_scale_code,
    input  wire logic                    logic_reset_n,
    input  wire logic                    low_power_n,
    // analog front end
    input  wire logic                    chop_trip,
    input  wire logic                    current_zero,
    input  wire logic                    ocp_sustained,
    // bridge and supply control
    output hbridge_chop_pkg::gate_t      bridge_gate,
    output logic [6:0]                   scale_pct,
    output logic                         pump_run,
    output logic                         aux_regulator_on,
    output logic                         clocks_run,
    output logic                         drive_ready,
    // open-drain fault pin
    output logic                         fault_n_o,
    output logic                         fault_n_oe
);
    localparam int WW = $clog2(WAKE_CYC + 1);

    hbridge_chop_pkg::pin_t   pin_raw;
    hbridge_chop_pkg::pin_t   s1_r, s2_r, s3_r, pin_r, pin_nxt;
    hbridge_chop_pkg::state_t state_r, state_nxt;
    hbridge_chop_pkg::decay_t mode;
    hbridge_chop_pkg::state_t decay_entry;
    hbridge_chop_pkg::gate_t  gate_r, gate_nxt;
    logic [11:0]              cnt_r, cnt_nxt;
    logic [10:0]              per_r, per_nxt;
    logic [WW-1:0]            wake_r, wake_nxt;
    logic                     ready_r, ready_nxt;
    logic                     fault_r, fault_nxt;
    logic                     dir_r, dir_nxt;
    logic                     en_prev_r;
    logic [6:0]               scale_r, scale_nxt;
    logic                     sup_r, sup_nxt;
    logic                     halt, ignore, en, period_end, restart;

    // undriven pins are pulled low in the pad, so they arrive as 0
    assign pin_raw = '{ocp: ocp_sustained, lp_n: low_power_n,
                       lrst_n: logic_reset_n,
                       decay_open: recirculation_open,
                       decay_lvl: recirculation_select,
                       en: bridge_enable_in, dir: direction_select,
                       code: current_scale_code};

    // a bit only changes once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < hbridge_chop_pkg::PIN_W; gi++)
        begin : g_filt
            assign pin_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s2_r[gi]
                                                        : pin_r[gi];
        end
    endgenerate

    // three-stage synchroniser and glitch filter
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1_r  <= hbridge_chop_pkg::PIN_RESET;
            s2_r  <= hbridge_chop_pkg::PIN_RESET;
            s3_r  <= hbridge_chop_pkg::PIN_RESET;
            pin_r <= hbridge_chop_pkg::PIN_RESET;
        end
        else
        begin
            s1_r  <= pin_raw;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            pin_r <= pin_nxt;
        end
    end

    // decay mode: open pin wins, then level
    always_comb
    begin
        if (pin_r.decay_open)
            mode = hbridge_chop_pkg::DK_MIXED;
        else if (pin_r.decay_lvl)
            mode = hbridge_chop_pkg::DK_FAST;
        else
            mode = hbridge_chop_pkg::DK_SLOW;
        decay_entry = (mode == hbridge_chop_pkg::DK_SLOW)
                    ? hbridge_chop_pkg::ST_SLOW : hbridge_chop_pkg::ST_REV;
    end

    assign ignore     = !pin_r.lrst_n || !pin_r.lp_n;
    assign halt       = ignore || !ready_r || fault_r;
    assign en         = pin_r.en;
    assign period_end = (per_r == hbridge_chop_pkg::PWM_CYC - 11'h001);

    // supervisor: wake delay, fault latch, supplies, scale code
    always_comb
    begin
        sup_nxt   = pin_r.lp_n;
        wake_nxt  = wake_r;
        ready_nxt = ready_r;
        if (!pin_r.lp_n)
        begin
            wake_nxt  = '0;
            ready_nxt = 1'b0;
        end
        else if (wake_r == WW'(WAKE_CYC - 1))
            ready_nxt = 1'b1;
        else
            wake_nxt = wake_r + WW'(1);
        // set wins over the clear by logic reset
        if (pin_r.ocp)
            fault_nxt = 1'b1;
        else if (!pin_r.lrst_n)
            fault_nxt = 1'b0;
        else
            fault_nxt = fault_r;
        scale_nxt = ignore ? scale_r
                  : hbridge_chop_pkg::SCALE_PCT[pin_r.code];
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sup_r   <= 1'b0;
            wake_r  <= '0;
            ready_r <= 1'b0;
            fault_r <= 1'b0;
            scale_r <= 7'h00;
        end
        else
        begin
            sup_r   <= sup_nxt;
            wake_r  <= wake_nxt;
            ready_r <= ready_nxt;
            fault_r <= fault_nxt;
            scale_r <= scale_nxt;
        end
    end

    // bridge state machine; trip and zero are already synchronous
    always_comb
    begin
        state_nxt = state_r;
        dir_nxt   = dir_r;
        restart   = 1'b0;
        if (halt)
            state_nxt = hbridge_chop_pkg::ST_HALT;
        else if (en && (!en_prev_r
                 || state_r == hbridge_chop_pkg::ST_HALT))
        begin
            state_nxt = hbridge_chop_pkg::ST_DRIVE;
            restart   = 1'b1;
        end
        else
        begin
            unique case (state_r)
                hbridge_chop_pkg::ST_HALT:
                    state_nxt = decay_entry;
                hbridge_chop_pkg::ST_DRIVE:
                    // comparator ignored during the blanking interval
                    if (!en || (chop_trip
                        && cnt_r >= hbridge_chop_pkg::BLANK_CYC))
                        state_nxt = decay_entry;
                hbridge_chop_pkg::ST_REV:
                    if (en && period_end)
                        state_nxt = hbridge_chop_pkg::ST_DRIVE;
                    else if (current_zero)
                        // released at zero so the motor never reverses
                        state_nxt = (mode == hbridge_chop_pkg::DK_SLOW)
                                  ? hbridge_chop_pkg::ST_SLOW
                                  : hbridge_chop_pkg::ST_COAST;
                    else if (mode == hbridge_chop_pkg::DK_SLOW
                             || (mode == hbridge_chop_pkg::DK_MIXED
                             && cnt_r >= hbridge_chop_pkg::MIX_FAST_CYC))
                        state_nxt = hbridge_chop_pkg::ST_SLOW;
                hbridge_chop_pkg::ST_SLOW:
                    if (en && period_end)
                        state_nxt = hbridge_chop_pkg::ST_DRIVE;
                    else if (!en && mode == hbridge_chop_pkg::DK_FAST)
                        state_nxt = hbridge_chop_pkg::ST_REV;
                hbridge_chop_pkg::ST_COAST:
                    if (en && period_end)
                        state_nxt = hbridge_chop_pkg::ST_DRIVE;
                    else if (!en && mode == hbridge_chop_pkg::DK_SLOW)
                        state_nxt = hbridge_chop_pkg::ST_SLOW;
                default:
                    state_nxt = hbridge_chop_pkg::ST_HALT;
            endcase
        end
        if (state_nxt == hbridge_chop_pkg::ST_DRIVE)
            dir_nxt = pin_r.dir;
        // time in state; saturates so a long brake cannot wrap
        if (state_nxt != state_r)
            cnt_nxt = 12'h000;
        else
            cnt_nxt = (cnt_r == 12'hfff) ? cnt_r : cnt_r + 12'h001;
        // period restarts with the enable so blanking starts clean
        if (halt || restart || period_end)
            per_nxt = 11'h000;
        else
            per_nxt = per_r + 11'h001;
        // gate decode of the next state
        gate_nxt = '0;
        unique case (state_nxt)
            hbridge_chop_pkg::ST_DRIVE:
                gate_nxt = dir_nxt ? 4'b1001 : 4'b0110;
            hbridge_chop_pkg::ST_REV:
                gate_nxt = dir_r ? 4'b0110 : 4'b1001;
            hbridge_chop_pkg::ST_SLOW:
                gate_nxt = 4'b0101;
            default:
                gate_nxt = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r   <= hbridge_chop_pkg::ST_HALT;
            dir_r     <= 1'b0;
            cnt_r     <= 12'h000;
            per_r     <= 11'h000;
            gate_r    <= '0;
            en_prev_r <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            dir_r     <= dir_nxt;
            cnt_r     <= cnt_nxt;
            per_r     <= per_nxt;
            gate_r    <= gate_nxt;
            en_prev_r <= en && !halt;
        end
    end

    assign bridge_gate      = gate_r;
    assign scale_pct        = scale_r;
    assign pump_run         = sup_r;
    assign aux_regulator_on = sup_r;
    assign clocks_run       = sup_r;
    assign drive_ready      = ready_r;
    assign fault_n_o        = 1'b0;
    assign fault_n_oe       = fault_r;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_dir_high;
        state_r == hbridge_chop_pkg::ST_DRIVE && !halt && en
        && pin_r.dir && !chop_trip |=> gate_r == 4'b1001;
    endproperty
    a_dir_high: assert property (p_dir_high)
        else $error("forward drive gates wrong");
    property p_no_drive_disabled;
        !en |=> state_r != hbridge_chop_pkg::ST_DRIVE;
    endproperty
    a_no_drive_disabled: assert property (p_no_drive_disabled)
        else $error("drive while enable low");
    property p_brake;
        !halt && !en && mode == hbridge_chop_pkg::DK_SLOW
        |=> gate_r == 4'b0101;
    endproperty
    a_brake: assert property (p_brake)
        else $error("brake not applied");
    property p_coast;
        !halt && !en && mode == hbridge_chop_pkg::DK_FAST
        && state_r == hbridge_chop_pkg::ST_REV && current_zero
        |=> state_r == hbridge_chop_pkg::ST_COAST && gate_r == 4'b0000;
    endproperty
    a_coast: assert property (p_coast)
        else $error("no coast after zero current");
    property p_mixed;
        !halt && mode == hbridge_chop_pkg::DK_MIXED && !current_zero
        && state_r == hbridge_chop_pkg::ST_REV && !(en && period_end)
        && cnt_r >= hbridge_chop_pkg::MIX_FAST_CYC
        |=> state_r == hbridge_chop_pkg::ST_SLOW;
    endproperty
    a_mixed: assert property (p_mixed)
        else $error("mixed decay did not go slow");
    property p_new_period;
        !halt && en && period_end && (state_r inside
        {hbridge_chop_pkg::ST_REV, hbridge_chop_pkg::ST_SLOW,
         hbridge_chop_pkg::ST_COAST})
        |=> state_r == hbridge_chop_pkg::ST_DRIVE;
    endproperty
    a_new_period: assert property (p_new_period)
        else $error("drive not resumed at period start");
    property p_scale;
        !ignore && pin_r.code == 5'h0f |=> scale_r == 7'h43;
    endproperty
    a_scale: assert property (p_scale)
        else $error("scale for code 0f wrong");
    property p_scale_top;
        !ignore && pin_r.code == 5'h1e |=> scale_r == 7'h64;
    endproperty
    a_scale_top: assert property (p_scale_top)
        else $error("scale for code 1e wrong");
    property p_slow_chop;
        !halt && en && en_prev_r && state_r == hbridge_chop_pkg::ST_DRIVE
        && chop_trip && cnt_r >= hbridge_chop_pkg::BLANK_CYC
        && mode == hbridge_chop_pkg::DK_SLOW |=> gate_r == 4'b0101;
    endproperty
    a_slow_chop: assert property (p_slow_chop)
        else $error("slow decay gates wrong");
    property p_fast_chop;
        !halt && en && en_prev_r && state_r == hbridge_chop_pkg::ST_DRIVE
        && chop_trip && cnt_r >= hbridge_chop_pkg::BLANK_CYC
        && mode == hbridge_chop_pkg::DK_FAST
        |=> state_r == hbridge_chop_pkg::ST_REV && gate_r != 4'b0000;
    endproperty
    a_fast_chop: assert property (p_fast_chop)
        else $error("fast decay not entered");
    property p_blank;
        !halt && en && en_prev_r && state_r == hbridge_chop_pkg::ST_DRIVE
        && cnt_r < hbridge_chop_pkg::BLANK_CYC
        |=> state_r == hbridge_chop_pkg::ST_DRIVE;
    endproperty
    a_blank: assert property (p_blank)
        else $error("trip acted inside blanking");
    property p_lreset;
        !pin_r.lrst_n |=> state_r == hbridge_chop_pkg::ST_HALT
                          && gate_r == 4'b0000;
    endproperty
    a_lreset: assert property (p_lreset)
        else $error("bridge active in logic reset");
    property p_sleep;
        !pin_r.lp_n |=> !pump_run && !aux_regulator_on && !clocks_run
                        && gate_r == 4'b0000;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep did not stop supplies");
    property p_wake;
        $rose(pin_r.lp_n) |=> !ready_r [*8];
    endproperty
    a_wake: assert property (p_wake)
        else $error("ready too soon after wake");
    property p_fault;
        pin_r.ocp |=> fault_n_oe ##1 gate_r == 4'b0000;
    endproperty
    a_fault: assert property (p_fault)
        else $error("overcurrent not latched");
    property p_fault_hold;
        fault_r && pin_r.lrst_n |=> fault_r;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault cleared without reset");
    c_chop_slow: cover property (state_r == hbridge_chop_pkg::ST_DRIVE
        ##1 state_r == hbridge_chop_pkg::ST_SLOW);
    c_coast: cover property (state_r == hbridge_chop_pkg::ST_REV
        ##1 state_r == hbridge_chop_pkg::ST_COAST);
    c_wake: cover property ($rose(ready_r));
    c_fault: cover property ($rose(fault_r));
endmodule

// >>> tb_top.sv
// self-checking bench for the h-bridge chop controller
`timescale 1ns/1ps
module tb_top;
    localparam int         WAKE = 32;
    localparam logic [3:0] G_FWD = 4'h9;
    localparam logic [3:0] G_REV = 4'h6;
    localparam logic [3:0] G_BRK = 4'h5;
    localparam logic [3:0] G_OFF = 4'h0;
    logic                    sys_clk, reset_n, direction_select;
    logic                    bridge_enable_in, recirculation_select;
    logic                    recirculation_open, logic_reset_n, low_power_n;
    logic [4:0]              current_scale_code;
    logic                    chop_trip, current_zero, ocp_sustained;
    hbridge_chop_pkg::gate_t bridge_gate;
    logic [6:0]              scale_pct;
    logic                    pump_run, aux_regulator_on, clocks_run;
    logic                    drive_ready, fault_n_o, fault_n_oe;
    int                      mismatches, num_checks, n, k;
    logic [3:0]              early_tab [3] = '{4'h5, 4'h6, 4'h6};
    logic [3:0]              late_tab  [3] = '{4'h5, 4'h0, 4'h5};
    int pct_tab [32] = '{0, 5, 10, 15, 20, 24, 29, 34, 38, 43, 47, 51, 56,
        60, 63, 67, 71, 74, 77, 80, 83, 86, 88, 90, 92, 94, 96, 97, 98, 99,
        100, 100};

    hbridge_current_chop_control #(.WAKE_CYC(WAKE))
        hbridge_current_chop_control_inst (
        .sys_clk(sys_clk), .reset_n(reset_n),
        .direction_select(direction_select),
        .bridge_enable_in(bridge_enable_in),
        .recirculation_select(recirculation_select),
        .recirculation_open(recirculation_open),
        .current_scale_code(current_scale_code),
        .logic_reset_n(logic_reset_n), .low_power_n(low_power_n),
        .chop_trip(chop_trip), .current_zero(current_zero),
        .ocp_sustained(ocp_sustained), .bridge_gate(bridge_gate),
        .scale_pct(scale_pct), .pump_run(pump_run),
        .aux_regulator_on(aux_regulator_on), .clocks_run(clocks_run),
        .drive_ready(drive_ready), .fault_n_o(fault_n_o),
        .fault_n_oe(fault_n_oe));

    winding_model winding_model_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .bridge_gate(bridge_gate),
        .scale_pct(scale_pct), .chop_trip(chop_trip),
        .current_zero(current_zero));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // inputs move 1 ns after the edge, outputs are read there too
    task automatic tick(input int cyc);
        repeat (cyc) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [11:0] exp,
                         input logic [11:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_gate(input logic [3:0] g, input int lim,
                             output int cyc);
        cyc = 0;
        while (bridge_gate !== g && cyc < lim)
        begin
            tick(1);
            cyc++;
        end
        check("gate", 12'(g), 12'(bridge_gate));
    endtask

    // bounded wait for the wake delay to finish
    task automatic wait_ready;
        n = 0;
        while (drive_ready !== 1'b1 && n < WAKE + 20)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic check_awake(input logic [11:0] exp);
        check("pump_run", exp, 12'(pump_run));
        check("aux_regulator_on", exp, 12'(aux_regulator_on));
        check("clocks_run", exp, 12'(clocks_run));
        check("drive_ready", exp, 12'(drive_ready));
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        mismatches++;
        $display("watchdog ran out");
        report_and_stop();
    end

    initial
    begin
        mismatches = 0;
        num_checks = 0;
        reset_n = 1'b0;
        direction_select = 1'b1;
        bridge_enable_in = 1'b0;
        recirculation_select = 1'b0;
        recirculation_open = 1'b0;
        current_scale_code = 5'h1f;
        logic_reset_n = 1'b1;
        low_power_n = 1'b1;
        ocp_sustained = 1'b0;
        tick(8);
        check("gate in reset", 12'(G_OFF), 12'(bridge_gate));
        reset_n = 1'b1;
        tick(WAKE / 2);
        check("early ready", 12'h000, 12'(drive_ready));
        wait_ready();
        check_awake(12'h001);
        $display("test wake done");
        // direction, enable and brake on disable
        for (int d = 0; d < 2; d++)
        begin
            direction_select = d[0];
            bridge_enable_in = 1'b1;
            wait_gate(d[0] ? G_FWD : G_REV, 10, n);
            bridge_enable_in = 1'b0;
            wait_gate(G_BRK, 10, n);
            tick(80);
            check("brake held", 12'(G_BRK), 12'(bridge_gate));
        end
        direction_select = 1'b1;
        $display("test direction done");
        // disable in slow, fast and mixed decay
        for (int m = 0; m < 3; m++)
        begin
            recirculation_select = (m == 1);
            recirculation_open = (m == 2);
            bridge_enable_in = 1'b1;
            wait_gate(G_FWD, 10, n);
            tick(300);
            bridge_enable_in = 1'b0;
            tick(12);
            check("decay early", 12'(early_tab[m]), 12'(bridge_gate));
            tick(600);
            check("decay late", 12'(late_tab[m]), 12'(bridge_gate));
        end
        recirculation_open = 1'b0;
        $display("test disable decay done");
        // chopping with a threshold that trips as soon as it may
        // in slow, fast and mixed decay
        current_scale_code = 5'h00;
        for (int m = 0; m < 3; m++)
        begin
            recirculation_select = (m == 1);
            recirculation_open = (m == 2);
            tick(8);
            bridge_enable_in = 1'b1;
            wait_gate(G_FWD, 10, n);
            n = 0;
            while (bridge_gate === G_FWD && n < 2000)
            begin
                tick(1);
                n++;
            end
            check("on time", 12'(hbridge_chop_pkg::BLANK_CYC) + 12'h001,
                  12'(n));
            check("chop gate", 12'(m ? G_REV : G_BRK), 12'(bridge_gate));
            tick(400);
            check("chop rest", 12'((m == 1) ? G_OFF : G_BRK), 12'(bridge_gate));
            wait_gate(G_FWD, 2000, k);
            check("period", 12'(hbridge_chop_pkg::PWM_CYC), 12'(n + 400 + k));
            bridge_enable_in = 1'b0;
            tick(50);
        end
        recirculation_select = 1'b0;
        recirculation_open = 1'b0;
        $display("test chop done");
        for (int c = 0; c < 32; c++)
        begin
            current_scale_code = 5'(c);
            tick(8);
            check("scale_pct", 12'(pct_tab[c]), 12'(scale_pct));
        end
        $display("test scale done");
        // logic reset stops the bridge and ignores the code pins
        bridge_enable_in = 1'b1;
        wait_gate(G_FWD, 10, n);
        logic_reset_n = 1'b0;
        current_scale_code = 5'h05;
        tick(10);
        check("gate held", 12'(G_OFF), 12'(bridge_gate));
        check("scale frozen", 12'h064, 12'(scale_pct));
        logic_reset_n = 1'b1;
        tick(10);
        check("scale after", 12'h018, 12'(scale_pct));
        wait_gate(G_FWD, 10, n);
        $display("test logic reset done");
        // overcurrent latches until a logic reset
        ocp_sustained = 1'b1;
        tick(8);
        ocp_sustained = 1'b0;
        tick(20);
        check("fault_n_oe", 12'h001, 12'(fault_n_oe));
        check("fault_n_o", 12'h000, 12'(fault_n_o));
        check("fault gate", 12'(G_OFF), 12'(bridge_gate));
        logic_reset_n = 1'b0;
        tick(8);
        logic_reset_n = 1'b1;
        tick(8);
        check("fault cleared", 12'h000, 12'(fault_n_oe));
        wait_gate(G_FWD, 10, n);
        $display("test fault done");
        // sleep and wake delay
        low_power_n = 1'b0;
        tick(8);
        check_awake(12'h000);
        check("sleep gate", 12'(G_OFF), 12'(bridge_gate));
        low_power_n = 1'b1;
        tick(WAKE / 2);
        check("wake ready", 12'h000, 12'(drive_ready));
        wait_ready();
        check_awake(12'h001);
        bridge_enable_in = 1'b0;
        $display("test sleep done");
        report_and_stop();
    end
endmodule

// >>> winding_model.sv
// winding and sense comparator model feeding the chop controller
`timescale 1ns/1ps
module winding_model #(
    parameter int REF_GAIN = 10
) (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    // bridge state and current setting from the controller
    input  wire hbridge_chop_pkg::gate_t bridge_gate,
    input  wire logic [6:0]              scale_pct,
    // comparator result and zero detect back to the controller
    output logic                         chop_trip,
    output logic                         current_zero
);
    int         level_r;
    int         level_nxt;
    int         mag;
    logic [1:0] slow_div_r;

    // drive ramps the winding, reverse pulls it back, brake bleeds slowly
    always_comb
    begin
        level_nxt = level_r;
        case (bridge_gate)
            4'h9: level_nxt = level_r + 1;
            4'h6: level_nxt = level_r - 1;
            4'h5:
                if (slow_div_r == 2'h0 && level_r != 0)
                    level_nxt = (level_r > 0) ? level_r - 1 : level_r + 1;
            default: level_nxt = 0; // open bridge: nothing recirculates
        endcase
    end

    // reverse past zero is not clamped, so a late release shows up
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            level_r    <= 0;
            slow_div_r <= 2'h0;
        end
        else
        begin
            level_r    <= level_nxt;
            slow_div_r <= slow_div_r + 2'h1;
        end
    end

    // sense times five against scaled reference; code zero trips at once
    assign mag          = (level_r < 0) ? -level_r : level_r;
    assign chop_trip    = (mag * 5) >= (int'(scale_pct) * REF_GAIN);
    assign current_zero = (level_r == 0);
endmodule
